// [hdl/pmvm_pkg.sv]
package pmvm_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ROM_BYTES_DEF = 4096;
  localparam int NUM_SRC = 8;
  localparam logic [15:0] VEC_BASE = 16'h0000;
  localparam logic [15:0] VEC_LAST = 16'h0013;
  localparam logic [15:0] TABLE_CALL_INSTRUCTION_BASE = 16'h0040;
  localparam logic [15:0] TABLE_CALL_INSTRUCTION_LAST = 16'h007F;
  localparam logic [15:0] OPTION_ADDR = 16'h0080;
  localparam logic [15:0] PROTECT_ADDR = 16'h0081;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam int PSW_IE_BIT = 7;
  localparam int RESET_PIN_SEL_BIT = 0;
  // Vector slot per source index: 0 reset, 1 low-voltage, 2/3 external, 4 timer8,
  // 5/6 timer16 compares, 7 converter
  localparam logic [15:0] VEC_SLOT [NUM_SRC] = '{
    16'h0000, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010, 16'h0012
  };
  typedef enum logic [2:0] {
    PMVM_BOOT  = 3'b000,
    PMVM_OPT   = 3'b001,
    PMVM_PROT  = 3'b011,
    PMVM_VLO   = 3'b010,
    PMVM_VHI   = 3'b110,
    PMVM_RUN   = 3'b111,
    PMVM_ACK   = 3'b101
  } pmvm_state_t;
endpackage

// [hdl/pmvm_fetch_if.sv]
`timescale 1ns/1ps
interface pmvm_fetch_if;
  logic [15:0] addr;
  logic [7:0] rdata;
  modport ctrl (output addr, input rdata);
  modport mem (input addr, output rdata);
endinterface

// [hdl/pmvm_rom.sv]
`timescale 1ns/1ps
module pmvm_rom #(
  parameter int ROM_BYTES = pmvm_pkg::ROM_BYTES_DEF
) (
  input wire logic sys_clk,
  input wire logic prog_we,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] prog_data,
  pmvm_fetch_if.mem port
);
  localparam int AW = $clog2(ROM_BYTES);
  logic [7:0] mem_q [ROM_BYTES];
  logic [7:0] rdata_q;
  logic in_range;
  // Flash starts at zero; bytes above the part's size read as erased ones
  assign in_range = (port.addr < 16'(ROM_BYTES));
  always_ff @(posedge sys_clk) begin
    if (prog_we && (prog_addr < 16'(ROM_BYTES))) begin
      mem_q[prog_addr[AW-1:0]] <= prog_data;
    end
    rdata_q <= in_range ? mem_q[port.addr[AW-1:0]] : 8'hFF;
  end
  assign port.rdata = rdata_q;
endmodule

// [hdl/pmvm_top.sv]
`timescale 1ns/1ps
module pmvm_top #(
  parameter int ROM_BYTES = pmvm_pkg::ROM_BYTES_DEF
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic reset_pin_n,
  input wire logic prog_we,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] prog_data,
  input wire logic [pmvm_pkg::NUM_SRC-1:0] irq_ack,
  input wire logic advance,
  input wire logic [15:0] advance_step,
  input wire logic branch,
  input wire logic [15:0] branch_target,
  input wire logic table_call,
  input wire logic [4:0] table_index,
  input wire logic return_from_interrupt,
  input wire logic [7:0] psw_restore,
  input wire logic [7:0] psw_in,
  output logic [15:0] program_counter,
  output logic [7:0] fetch_byte,
  output logic fetch_valid,
  output logic global_irq_enable_flag,
  output logic [7:0] saved_psw,
  output logic psw_save_strobe,
  output logic [7:0] option_byte,
  output logic [7:0] protect_byte,
  output logic reset_pin_as_port,
  output logic port_level,
  output logic vector_fetch_fault,
  output logic core_in_reset
);
  pmvm_fetch_if fif ();
  pmvm_rom #(.ROM_BYTES(ROM_BYTES)) u_rom (
    .sys_clk(sys_clk),
    .prog_we(prog_we),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .port(fif)
  );

  // Pin is asynchronous: two flops before anything looks at it
  // Reset to the pulled-up idle level so release does not look like a pin reset
  logic pin_s1_q, pin_s2_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= reset_pin_n;
      pin_s2_q <= pin_s1_q;
    end
  end

  pmvm_pkg::pmvm_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] vlo_q, vlo_d;
  logic [7:0] opt_q, opt_d;
  logic [7:0] prot_q, prot_d;
  logic port_mode_q, port_mode_d;
  logic ie_q, ie_d;
  logic [7:0] saved_q, saved_d;
  logic save_q, save_d;
  logic fvalid_q, fvalid_d;
  logic fault_q, fault_d;
  logic rst_q, rst_d;
  logic port_lvl_q, port_lvl_d;
  logic wait_q, wait_d;
  logic pin_reset;
  logic [2:0] ack_src;
  logic ack_any;

  // Lowest index from 1 up wins when several sources are acknowledged together; bit 0 (reset) is never taken
  always_comb begin
    ack_src = 3'd0;
    ack_any = 1'b0;
    for (int i = pmvm_pkg::NUM_SRC - 1; i >= 1; i--) begin
      if (irq_ack[i]) begin
        ack_src = 3'(i);
        ack_any = 1'b1;
      end
    end
  end

  // Until the option byte has been read, the pin is always the reset input
  assign pin_reset = !pin_s2_q && !port_mode_q;

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    addr_d = addr_q;
    vlo_d = vlo_q;
    opt_d = opt_q;
    prot_d = prot_q;
    port_mode_d = port_mode_q;
    ie_d = ie_q;
    saved_d = saved_q;
    save_d = 1'b0;
    fvalid_d = 1'b0;
    fault_d = 1'b0;
    rst_d = rst_q;
    port_lvl_d = port_mode_q ? pin_s2_q : 1'b0;
    wait_d = 1'b0;
    // Each read state lasts two cycles: the ROM data for addr_q lands one edge late
    unique case (state_q)
      pmvm_pkg::PMVM_BOOT: begin
        rst_d = 1'b1;
        addr_d = pmvm_pkg::OPTION_ADDR;
        wait_d = !wait_q;
        if (wait_q) begin
          state_d = pmvm_pkg::PMVM_OPT;
        end
      end
      pmvm_pkg::PMVM_OPT: begin
        wait_d = !wait_q;
        if (wait_q) begin
          opt_d = fif.rdata;
          addr_d = pmvm_pkg::PROTECT_ADDR;
          state_d = pmvm_pkg::PMVM_PROT;
        end
      end
      pmvm_pkg::PMVM_PROT: begin
        wait_d = !wait_q;
        if (wait_q) begin
          prot_d = fif.rdata;
          // Alternate port use only now, after the power-on reset phase
          port_mode_d = opt_q[pmvm_pkg::RESET_PIN_SEL_BIT];
          addr_d = pmvm_pkg::VEC_BASE;
          state_d = pmvm_pkg::PMVM_VLO;
        end
      end
      pmvm_pkg::PMVM_VLO: begin
        wait_d = !wait_q;
        if (wait_q) begin
          vlo_d = fif.rdata;
          addr_d = addr_q + pmvm_pkg::ADDR_STEP;
          state_d = pmvm_pkg::PMVM_VHI;
        end
      end
      pmvm_pkg::PMVM_VHI: begin
        wait_d = !wait_q;
        if (wait_q) begin
          pc_d = {fif.rdata, vlo_q};
          addr_d = pc_d;
          rst_d = 1'b0;
          state_d = pmvm_pkg::PMVM_RUN;
        end
      end
      pmvm_pkg::PMVM_ACK: begin
        addr_d = pmvm_pkg::VEC_SLOT[ack_src];
        state_d = pmvm_pkg::PMVM_VLO;
      end
      pmvm_pkg::PMVM_RUN: begin
        fvalid_d = 1'b1;
        fault_d = (addr_q <= pmvm_pkg::VEC_LAST);
        if (ack_any) begin
          ie_d = 1'b0;
          saved_d = psw_in;
          save_d = 1'b1;
          fvalid_d = 1'b0;
          addr_d = pmvm_pkg::VEC_SLOT[ack_src];
          state_d = pmvm_pkg::PMVM_VLO;
        end else if (table_call) begin
          addr_d = pmvm_pkg::TABLE_CALL_INSTRUCTION_BASE + {10'd0, table_index, 1'b0};
          fvalid_d = 1'b0;
          state_d = pmvm_pkg::PMVM_VLO;
        end else begin
          if (return_from_interrupt) begin
            ie_d = psw_restore[pmvm_pkg::PSW_IE_BIT];
          end
          if (branch) begin
            pc_d = branch_target;
          end else if (advance) begin
            pc_d = pc_q + advance_step;
          end
          addr_d = pc_d;
        end
      end
      default: begin
        state_d = pmvm_pkg::PMVM_BOOT;
      end
    endcase
    if (pin_reset) begin
      state_d = pmvm_pkg::PMVM_BOOT;
      rst_d = 1'b1;
      fvalid_d = 1'b0;
      save_d = 1'b0;
      ie_d = pmvm_pkg::PSW_RESET[pmvm_pkg::PSW_IE_BIT];
    end
  end

  assign fif.addr = addr_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= pmvm_pkg::PMVM_BOOT;
      pc_q <= 16'h0000;
      addr_q <= 16'h0000;
      vlo_q <= 8'h00;
      opt_q <= 8'h00;
      prot_q <= 8'h00;
      port_mode_q <= 1'b0;
      ie_q <= 1'b0;
      saved_q <= 8'h00;
      save_q <= 1'b0;
      fvalid_q <= 1'b0;
      fault_q <= 1'b0;
      rst_q <= 1'b1;
      port_lvl_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      addr_q <= addr_d;
      vlo_q <= vlo_d;
      opt_q <= opt_d;
      prot_q <= prot_d;
      port_mode_q <= port_mode_d;
      ie_q <= ie_d;
      saved_q <= saved_d;
      save_q <= save_d;
      fvalid_q <= fvalid_d;
      fault_q <= fault_d;
      rst_q <= rst_d;
      port_lvl_q <= port_lvl_d;
      wait_q <= wait_d;
    end
  end

  // Fetch data comes from the ROM's output register
  assign fetch_byte = fif.rdata;
  assign program_counter = pc_q;
  assign fetch_valid = fvalid_q;
  assign global_irq_enable_flag = ie_q;
  assign saved_psw = saved_q;
  assign psw_save_strobe = save_q;
  assign option_byte = opt_q;
  assign protect_byte = prot_q;
  assign reset_pin_as_port = port_mode_q;
  assign port_level = port_lvl_q;
  assign vector_fetch_fault = fault_q;
  assign core_in_reset = rst_q;
endmodule

// [bench/pmvm_asserts.sv]
`timescale 1ns/1ps
module pmvm_asserts (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic reset_pin_n,
  input wire logic [7:0] irq_ack,
  input wire logic advance,
  input wire logic [15:0] advance_step,
  input wire logic branch,
  input wire logic [15:0] branch_target,
  input wire logic table_call,
  input wire logic [7:0] psw_in,
  input wire logic [15:0] program_counter,
  input wire logic fetch_valid,
  input wire logic global_irq_enable_flag,
  input wire logic [7:0] saved_psw,
  input wire logic psw_save_strobe,
  input wire logic reset_pin_as_port,
  input wire logic vector_fetch_fault,
  input wire logic core_in_reset
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  logic run;
  logic ack;
  assign run = fetch_valid && !core_in_reset;
  assign ack = run && (irq_ack[7:1] != 7'h00);
  a_ack_saves_psw: assert property (ack |=> !global_irq_enable_flag && psw_save_strobe
    && saved_psw == $past(psw_in)) else $error("ack did not save status");
  a_ack_vector_load: assert property (ack |=> !fetch_valid [*4])
    else $error("vector load too short");
  a_strobe_single: assert property (psw_save_strobe |=> !psw_save_strobe)
    else $error("save strobe too long");
  a_branch_to_target: assert property (run && branch && !table_call && !ack
    |=> program_counter == $past(branch_target)) else $error("branch pc wrong");
  a_advance_pc_step: assert property (run && advance && !branch && !table_call && !ack
    |=> program_counter == $past(program_counter) + $past(advance_step))
    else $error("advance pc wrong");
  a_boot_bounded: assert property ($rose(arst_n) && reset_pin_n
    |-> ##[1:16] !core_in_reset) else $error("boot did not finish");
  a_fault_in_table: assert property (vector_fetch_fault
    |-> $past(program_counter) <= pmvm_pkg::VEC_LAST) else $error("fault outside table");
  a_pin_resets_core: assert property ((!reset_pin_n && !reset_pin_as_port) [*5]
    |-> core_in_reset) else $error("pin low did not reset");
endmodule
bind pmvm_top pmvm_asserts u_pmvm_asserts (.*);

// [bench/pmvm_core_model.sv]
`timescale 1ns/1ps
module pmvm_core_model (
  input wire logic sys_clk,
  output logic [7:0] irq_ack,
  output logic advance,
  output logic [15:0] advance_step,
  output logic branch,
  output logic [15:0] branch_target,
  output logic table_call,
  output logic [4:0] table_index,
  output logic return_from_interrupt,
  output logic [7:0] psw_restore,
  output logic [7:0] psw_in
);
  initial begin
    {irq_ack, advance, branch, table_call, return_from_interrupt} = '0;
    advance_step = 16'h0001;
    branch_target = 16'h0000;
    table_index = 5'h00;
    psw_restore = 8'h80;
    psw_in = 8'h82;
  end
  // A request stands for exactly one rising edge, like a real fetch stage
  task automatic issue(input int kind, input logic [15:0] val);
    @(negedge sys_clk);
    advance_step = val;
    branch_target = val;
    table_index = val[4:0];
    irq_ack = (kind == 3) ? val[7:0] : 8'h00;
    advance = (kind == 0);
    branch = (kind == 1);
    table_call = (kind == 2);
    return_from_interrupt = (kind == 4);
    @(negedge sys_clk);
    {irq_ack, advance, branch, table_call, return_from_interrupt} = '0;
  endtask
endmodule

// [bench/pmvm_top_tb.sv]
`timescale 1ns/1ps
module pmvm_top_tb;
  logic sys_clk, arst_n, reset_pin_n, prog_we;
  logic [15:0] prog_addr, advance_step, branch_target, program_counter;
  logic [7:0] prog_data, irq_ack, psw_restore, psw_in, fetch_byte, saved_psw;
  logic [7:0] option_byte, protect_byte;
  logic [4:0] table_index;
  logic advance, branch, table_call, return_from_interrupt, fetch_valid;
  logic global_irq_enable_flag, psw_save_strobe, reset_pin_as_port, port_level;
  logic vector_fetch_fault, core_in_reset;
  int err_total, tests_run, cyc;
  pmvm_top #(.ROM_BYTES(1024)) u_pmvm_top (.*);
  pmvm_core_model u_pmvm_core_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    prog_we = 1'b1;
    prog_addr = a;
    prog_data = d;
    @(negedge sys_clk);
    prog_we = 1'b0;
  endtask
  task automatic wait_run();
    for (int n = 0; n < 40 && !(fetch_valid === 1'b1 && core_in_reset === 1'b0); n++) begin
      @(negedge sys_clk);
    end
    chk({15'h0000, core_in_reset}, 16'h0000);
  endtask
  task automatic boot(input logic [7:0] opt);
    arst_n = 1'b0;
    wr(16'h0080, opt);
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    if (reset_pin_n === 1'b0) begin
      repeat (20) @(negedge sys_clk);
      chk({15'h0000, core_in_reset}, 16'h0001);
      reset_pin_n = 1'b1;
    end
    wait_run();
    chk(program_counter, 16'h0123);
    chk({option_byte, protect_byte}, {opt, 8'h5A});
  endtask
  task automatic t_fetch();
    u_pmvm_core_model.issue(1, 16'h0300);
    u_pmvm_core_model.issue(0, 16'hFD00);
    chk(program_counter, 16'h0000);
    u_pmvm_core_model.issue(1, 16'h0400);
    @(negedge sys_clk);
    chk({8'h00, fetch_byte}, 16'h00FF);
    u_pmvm_core_model.issue(1, 16'h0004);
    repeat (2) @(negedge sys_clk);
    u_pmvm_core_model.issue(2, 16'd31);
    wait_run();
    chk(program_counter, 16'h0345);
  endtask
  task automatic t_irq();
    for (int i = 1; i < 8; i++) begin
      u_pmvm_core_model.issue(4, 16'h0000);
      chk({15'h0000, global_irq_enable_flag}, 16'h0001);
      u_pmvm_core_model.issue(3, 16'h0001 << i);
      chk({7'h00, global_irq_enable_flag, saved_psw}, 16'h0082);
      wait_run();
      chk(program_counter, {8'h02, 4'(i), 4'h0});
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    {arst_n, prog_we, prog_addr, prog_data} = '0;
    reset_pin_n = 1'b1;
    // Vector bytes: low at even address, high at odd
    for (int i = 1; i < 8; i++) begin
      wr(pmvm_pkg::VEC_SLOT[i], 8'(i << 4));
      wr(pmvm_pkg::VEC_SLOT[i] + 16'h0001, 8'h02);
    end
    wr(16'h007E, 8'h45);
    wr(16'h007F, 8'h03);
    wr(16'h0400, 8'h11);
    wr(16'h0081, 8'h5A);
    wr(16'h0000, 8'h23);
    wr(16'h0001, 8'h01);
    boot(8'h00);
    t_fetch();
    t_irq();
    reset_pin_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk({15'h0000, core_in_reset}, 16'h0001);
    reset_pin_n = 1'b1;
    wait_run();
    reset_pin_n = 1'b0;
    boot(8'h01);
    reset_pin_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk({14'h0000, core_in_reset, port_level}, 16'h0000);
    wrap_up();
  end
endmodule
